/* rpms_axil.sv */
// AXI4-Lite slave front end: one write and one read at a time, register access as strobes.
`timescale 1ns/1ps
`default_nettype none
`include "rpms_defs.svh"

module rpms_axil
	import rpms_pkg::*;
#(
	parameter int AW = 8
)
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_en,
	output logic [AW-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic wr_lane0,
	input wire logic wr_hit,
	output logic [AW-1:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_hit
);

	logic aw_ok;
	logic w_ok;
	logic ar_ok;
	logic b_done;
	logic r_done;
	logic [3:0] strb_q;

	// Address and data may arrive in either order; the response waits for both.
	assign aw_ok = s_axi_awvalid && s_axi_awready;
	assign w_ok = s_axi_wvalid && s_axi_wready;
	assign ar_ok = s_axi_arvalid && s_axi_arready;
	assign b_done = s_axi_bvalid && s_axi_bready;
	assign r_done = s_axi_rvalid && s_axi_rready;
	assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_lane0 = strb_q[0];
	assign rd_addr = s_axi_araddr;

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RPMS_RESP_OKAY;
			wr_addr <= '0;
			wr_data <= 32'h0;
			strb_q <= 4'h0;
		end
		else
		begin
			if (aw_ok)
			begin
				s_axi_awready <= 1'b0;
				wr_addr <= s_axi_awaddr;
			end
			if (w_ok)
			begin
				s_axi_wready <= 1'b0;
				wr_data <= s_axi_wdata;
				strb_q <= s_axi_wstrb;
			end
			if (wr_en)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `RPMS_RESP_OKAY : `RPMS_RESP_SLVERR;
			end
			if (b_done)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `RPMS_RESP_OKAY;
		end
		else if (ar_ok)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_hit ? rd_data : 32'h0;
			s_axi_rresp <= rd_hit ? `RPMS_RESP_OKAY : `RPMS_RESP_SLVERR;
		end
		else if (r_done)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

`default_nettype wire

/* rpms_defs.svh */
// Register offsets, field positions, reset values and timing counts of the reset pin and mode select block.
`ifndef RPMS_DEFS_SVH
`define RPMS_DEFS_SVH

`define RPMS_OFS_SOPT 8'h00
`define RPMS_OFS_RSS 8'h04
`define RPMS_OFS_FORCE 8'h08
`define RPMS_OFS_CLK 8'h0C
`define RPMS_OFS_IST 8'h10
`define RPMS_OFS_IMSK 8'h14

`define RPMS_SOPT_RPE 0
`define RPMS_SOPT_DPE 1

`define RPMS_RSS_POR 0
`define RPMS_RSS_PIN 1
`define RPMS_RSS_COP 2
`define RPMS_RSS_ILOP 3
`define RPMS_RSS_ILAD 4
`define RPMS_RSS_LVD 5
`define RPMS_RSS_FORCE 6
`define RPMS_RSS_W 7
`define RPMS_RSS_RESET 7'h01

`define RPMS_FORCE_BIT 0
`define RPMS_CLK_EXT 0
`define RPMS_CLK_DBG 1

`define RPMS_EV_PIN 0
`define RPMS_EV_DONE 1
`define RPMS_EV_W 2

`define RPMS_STRETCH_BUS 66
`define RPMS_BUS_DIV 2
`define RPMS_STRETCH_MIN 131

`define RPMS_RESP_OKAY 2'h0
`define RPMS_RESP_SLVERR 2'h2

`endif

/* rpms_partner.sv */
// Model of the reset switch and debug pod attached to the shared reset pin and the mode select pin.
`timescale 1ns/1ps
`default_nettype none

module rpms_partner
(
	input wire logic ref_clk,
	input wire logic press,
	input wire logic ms_low,
	input wire logic rst_pin_o,
	input wire logic rst_pin_oe_n,
	input wire logic rst_pin_pullup_en,
	output logic rst_pin_i,
	output logic mode_select_pin_i
);
	logic float_q = 1'b0;

	// A port pin that nobody drives and has no pull-up gets a changing level, so a stale value never looks valid.
	always_ff @(posedge ref_clk)
	begin
		float_q <= ~float_q;
	end

	// Open drain: the device or the switch pulls low, otherwise the pull-up holds the line high.
	assign rst_pin_i = (!rst_pin_oe_n) ? rst_pin_o : (press ? 1'b0 : (rst_pin_pullup_en ? 1'b1 : float_q));
	// The pod holds mode select low when asked; released, the internal pull-up wins.
	assign mode_select_pin_i = ms_low ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

/* rpms_pkg.sv */
// Types shared by the reset pin and mode select block.
package rpms_pkg;

	typedef enum logic [1:0]
	{
		RPMS_RUN = 2'h0,
		RPMS_HOLD = 2'h1,
		RPMS_REL = 2'h3
	} rpms_state_t;

	typedef logic [6:0] rpms_cause_t;

endpackage

/* rpms_stretch.sv */
// Down counter that holds busy for a fixed number of bus clock ticks after a start.
`timescale 1ns/1ps
`default_nettype none

module rpms_stretch
	import rpms_pkg::*;
#(
	parameter int COUNT = 66
)
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic start,
	input wire logic tick,
	output logic busy
);

	localparam int CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] LOAD = CW'(COUNT);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	assign cnt_d = start ? LOAD : ((tick && cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
	assign busy = (cnt_q != '0);

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

endmodule

`default_nettype wire

/* rpms_top.sv */
// Reset pin and mode select controller: pin function, reset stretching, cause flags and debug mode entry.
//
// Operation
// [RQ1] After power-on reset the shared pin is an ordinary port pin, not a reset input.
// [RQ2] Setting the reset pin enable bit makes the pin an open-drain active-low reset with a pull-up.
// [RQ3] Once enabled, the reset function stays on regardless of software until the next power-on reset.
// [RQ4] With the reset function on, an outside party pulling the pin low puts the device into reset.
// [RQ5] Every reset other than power-on drives the enabled pin low for about 66 bus clock cycles.
// [RQ6] Every reset records its cause as a flag in the reset source status register.
// [RQ7] A reset through the pin always ends in user mode, never in background debug mode.
// [RQ8] Debug mode is entered by mode select low at power-on, or by a forced reset with mode select low.
// [RQ9] Right after any reset the device runs from the internal clock generator, not the external one.
// [RQ10] The bus clock that times the stretching runs at exactly half the clock generator output.
// [RQ11] Mode select is sampled at the end of power-on or forced reset; left high it gives normal mode.
// [RQ12] The debug pin enable bit is set by every reset and only software clears it.
// [RQ13] The stretcher counts exactly 66 bus clock cycles and then releases the pin to its pull-up.
`timescale 1ns/1ps
`default_nettype none
`include "rpms_defs.svh"

module rpms_top
	import rpms_pkg::*;
#(
	parameter int AW = 8,
	parameter int STRETCH_BUS = `RPMS_STRETCH_BUS
)
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cop_rst_req,
	input wire logic ilop_rst_req,
	input wire logic ilad_rst_req,
	input wire logic lvd_rst_req,
	input wire logic rst_pin_i,
	output logic rst_pin_o,
	output logic rst_pin_oe_n,
	output logic rst_pin_pullup_en,
	output logic reset_pin_function,
	input wire logic mode_select_pin_i,
	output logic debug_pin_enable,
	output logic background_debug_mode,
	output logic sys_rst,
	output logic clock_internal_sel,
	output logic bus_clock,
	output logic irq
);

	rpms_state_t state_q;
	rpms_state_t state_d;
	rpms_cause_t cause_q;
	rpms_cause_t cause_d;
	rpms_cause_t rss_q;
	logic rst_pin_en_q;
	logic dpe_q;
	logic ext_clk_q;
	logic bdm_q;
	logic por_pend_q;
	logic force_pend_q;
	logic drive_q;
	logic bus_q;
	logic sys_rst_q;
	logic irq_q;
	logic pin_o_q;
	logic [`RPMS_EV_W-1:0] ist_q;
	logic [`RPMS_EV_W-1:0] imsk_q;

	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [31:0] wr_data;
	logic wr_lane0;
	logic wr_hit;
	logic [AW-1:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_hit;
	logic wr_sopt;
	logic wr_force;
	logic wr_clk;
	logic wr_ist;
	logic wr_imsk;
	logic pin_req;
	logic any_req;
	logic enter;
	logic stretch_busy;
	logic stretch_done;
	logic debug_cause;
	logic [`RPMS_EV_W-1:0] ev;
	logic [`RPMS_EV_W-1:0] ist_d;

	rpms_axil #(
		.AW(AW)
	) u_bus (
		.ref_clk(ref_clk),
		.srst(srst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_lane0(wr_lane0),
		.wr_hit(wr_hit),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_hit(rd_hit)
	);

	// Address decode; all fields sit in byte lane 0, so only that strobe matters.
	assign wr_sopt = wr_en && wr_lane0 && wr_addr == `RPMS_OFS_SOPT;
	assign wr_force = wr_en && wr_lane0 && wr_addr == `RPMS_OFS_FORCE;
	assign wr_clk = wr_en && wr_lane0 && wr_addr == `RPMS_OFS_CLK;
	assign wr_ist = wr_en && wr_lane0 && wr_addr == `RPMS_OFS_IST;
	assign wr_imsk = wr_en && wr_lane0 && wr_addr == `RPMS_OFS_IMSK;
	assign wr_hit = wr_addr == `RPMS_OFS_SOPT || wr_addr == `RPMS_OFS_RSS || wr_addr == `RPMS_OFS_FORCE
		|| wr_addr == `RPMS_OFS_CLK || wr_addr == `RPMS_OFS_IST || wr_addr == `RPMS_OFS_IMSK;
	assign rd_hit = rd_addr == `RPMS_OFS_SOPT || rd_addr == `RPMS_OFS_RSS || rd_addr == `RPMS_OFS_FORCE
		|| rd_addr == `RPMS_OFS_CLK || rd_addr == `RPMS_OFS_IST || rd_addr == `RPMS_OFS_IMSK;
	assign rd_data = (rd_addr == `RPMS_OFS_SOPT) ? {30'h0, dpe_q, rst_pin_en_q} :
		(rd_addr == `RPMS_OFS_RSS) ? {25'h0, rss_q} :
		(rd_addr == `RPMS_OFS_CLK) ? {30'h0, bdm_q, ext_clk_q} :
		(rd_addr == `RPMS_OFS_IST) ? {30'h0, ist_q} :
		(rd_addr == `RPMS_OFS_IMSK) ? {30'h0, imsk_q} : 32'h0;

	// The pin only counts as a reset request while it is not our own stretch pulse.
	assign pin_req = rst_pin_en_q && !rst_pin_i && state_q == RPMS_RUN; // [RQ4]
	assign any_req = por_pend_q || pin_req || cop_rst_req || ilop_rst_req || ilad_rst_req || lvd_rst_req
		|| force_pend_q;
	assign enter = state_q == RPMS_RUN && any_req;

	// One cause per reset, power-on first, forced debug reset last.
	always_comb
	begin
		cause_d = 7'h00;
		if (por_pend_q)
			cause_d[`RPMS_RSS_POR] = 1'b1;
		else if (pin_req)
			cause_d[`RPMS_RSS_PIN] = 1'b1;
		else if (cop_rst_req)
			cause_d[`RPMS_RSS_COP] = 1'b1;
		else if (ilop_rst_req)
			cause_d[`RPMS_RSS_ILOP] = 1'b1;
		else if (ilad_rst_req)
			cause_d[`RPMS_RSS_ILAD] = 1'b1;
		else if (lvd_rst_req)
			cause_d[`RPMS_RSS_LVD] = 1'b1;
		else if (force_pend_q)
			cause_d[`RPMS_RSS_FORCE] = 1'b1;
	end

	rpms_stretch #(
		.COUNT(STRETCH_BUS)
	) u_stretch (
		.ref_clk(ref_clk),
		.srst(srst),
		.start(enter),
		.tick(bus_q),
		.busy(stretch_busy)
	); // [RQ13]

	assign stretch_done = state_q == RPMS_HOLD && !stretch_busy;

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			RPMS_RUN:
				if (any_req)
					state_d = RPMS_HOLD;
			RPMS_HOLD:
				if (!stretch_busy)
					state_d = RPMS_REL;
			RPMS_REL:
				state_d = RPMS_RUN;
			default:
				state_d = RPMS_RUN;
		endcase
	end

	// Only power-on and forced resets may sample mode select; a pin reset never does.
	assign debug_cause = cause_q[`RPMS_RSS_POR] || cause_q[`RPMS_RSS_FORCE]; // [RQ7] [RQ8]

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			state_q <= RPMS_RUN;
			cause_q <= `RPMS_RSS_RESET;
			por_pend_q <= 1'b1;
			sys_rst_q <= 1'b1;
			bdm_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			if (enter)
			begin
				cause_q <= cause_d;
				por_pend_q <= 1'b0;
				sys_rst_q <= 1'b1;
			end
			if (state_q == RPMS_REL)
			begin
				sys_rst_q <= 1'b0;
				bdm_q <= debug_cause && !mode_select_pin_i; // [RQ8] [RQ11]
			end
		end
	end

	// A forced reset request waits in a flag so that a request during an active reset is not lost.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			force_pend_q <= 1'b0;
		else if (wr_force && wr_data[`RPMS_FORCE_BIT])
			force_pend_q <= 1'b1;
		else if (enter && cause_d[`RPMS_RSS_FORCE])
			force_pend_q <= 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			rss_q <= `RPMS_RSS_RESET;
		else if (enter)
			rss_q <= cause_d; // [RQ6]
	end

	// Power-on is the only thing that clears the pin function.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			rst_pin_en_q <= 1'b0; // [RQ1]
		else if (wr_sopt && wr_data[`RPMS_SOPT_RPE])
			rst_pin_en_q <= 1'b1; // [RQ2] [RQ3]
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			dpe_q <= 1'b1;
			ext_clk_q <= 1'b0;
		end
		else if (state_q != RPMS_RUN)
		begin
			dpe_q <= 1'b1; // [RQ12]
			ext_clk_q <= 1'b0; // [RQ9]
		end
		else
		begin
			if (wr_sopt)
				dpe_q <= wr_data[`RPMS_SOPT_DPE];
			if (wr_clk)
				ext_clk_q <= wr_data[`RPMS_CLK_EXT];
		end
	end

	// The pin is pulled low only for non-power-on resets and only while the stretcher runs.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			drive_q <= 1'b0;
		else if (enter)
			drive_q <= rst_pin_en_q && !cause_d[`RPMS_RSS_POR]; // [RQ5]
		else if (!stretch_busy)
			drive_q <= 1'b0; // [RQ13]
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			bus_q <= 1'b0;
		else
			bus_q <= !bus_q; // [RQ10]
	end

	// Status bits: the set wins over a write-one-to-clear in the same cycle.
	assign ev[`RPMS_EV_PIN] = enter && cause_d[`RPMS_RSS_PIN];
	assign ev[`RPMS_EV_DONE] = stretch_done && !cause_q[`RPMS_RSS_POR];
	assign ist_d = (ist_q & ~({`RPMS_EV_W{wr_ist}} & wr_data[`RPMS_EV_W-1:0])) | ev;

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			ist_q <= 2'h0;
			imsk_q <= 2'h0;
			irq_q <= 1'b0;
		end
		else
		begin
			ist_q <= ist_d;
			if (wr_imsk)
				imsk_q <= wr_data[`RPMS_EV_W-1:0];
			irq_q <= |(ist_d & (wr_imsk ? wr_data[`RPMS_EV_W-1:0] : imsk_q));
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			pin_o_q <= 1'b0;
		else
			pin_o_q <= 1'b0;
	end

	assign rst_pin_o = pin_o_q;
	assign rst_pin_oe_n = !drive_q;
	assign rst_pin_pullup_en = rst_pin_en_q;
	assign reset_pin_function = rst_pin_en_q;
	assign debug_pin_enable = dpe_q;
	assign background_debug_mode = bdm_q;
	assign sys_rst = sys_rst_q;
	assign clock_internal_sel = !ext_clk_q;
	assign bus_clock = bus_q;
	assign irq = irq_q;

	// Helper counter: length of the current low pulse driven on the pin.
	logic [8:0] low_cnt_q;

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			low_cnt_q <= 9'h000;
		else if (drive_q)
			low_cnt_q <= low_cnt_q + 9'h001;
		else
			low_cnt_q <= 9'h000;
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	a_por_gpio_mode: assert property ($fell(srst) |-> !reset_pin_function && rst_pin_oe_n) // [RQ1]
		else $error("Pin is not a port pin after power-on reset.");
	a_pin_enable_set: assert property (wr_sopt && wr_data[0] |=> reset_pin_function && rst_pin_pullup_en) // [RQ2]
		else $error("Reset pin function did not turn on.");
	a_pin_enable_kept: assert property (reset_pin_function |=> reset_pin_function) // [RQ3]
		else $error("Reset pin function dropped without power-on.");
	a_pin_low_reset: assert property (pin_req |=> sys_rst && rss_q[1]) // [RQ4]
		else $error("Pin pulled low did not reset the device.");
	a_stretch_length: assert property ($fell(drive_q) |-> low_cnt_q >= 9'(2 * STRETCH_BUS - 1) && low_cnt_q <= 9'(2 * STRETCH_BUS + 1)) // [RQ5]
		else $error("Pin low pulse length is not 66 bus cycles.");
	a_cause_recorded: assert property (enter |=> rss_q == $past(cause_d) && $onehot(rss_q)) // [RQ6]
		else $error("Reset cause flag not recorded.");
	a_pin_user_mode: assert property (state_q == RPMS_REL && cause_q[1] |=> !background_debug_mode) // [RQ7]
		else $error("Pin reset entered debug mode.");
	a_force_debug: assert property (state_q == RPMS_REL && cause_q[6] && !mode_select_pin_i
		|=> background_debug_mode ##1 !sys_rst) // [RQ8]
		else $error("Forced reset with mode select low missed debug mode.");
	a_normal_mode: assert property (state_q == RPMS_REL && mode_select_pin_i |=> !background_debug_mode) // [RQ11]
		else $error("Mode select high did not give normal mode.");
	a_internal_clock: assert property (state_q == RPMS_HOLD |=> clock_internal_sel) // [RQ9]
		else $error("External clock selected after reset.");
	a_bus_half_rate: assert property (bus_clock |=> !bus_clock ##1 bus_clock) // [RQ10]
		else $error("Bus clock is not half the generator rate.");
	a_debug_enable_set: assert property (state_q == RPMS_HOLD |=> debug_pin_enable) // [RQ12]
		else $error("Debug pin enable not set by reset.");
	a_pin_released: assert property ($fell(drive_q) |-> state_q == RPMS_REL && !stretch_busy) // [RQ13]
		else $error("Pin released at the wrong moment.");

	c_pin_reset: cover property (ev[0] ##[1:200] stretch_done);
	c_force_debug: cover property (state_q == RPMS_REL && cause_q[6] ##1 background_debug_mode);
	c_cop_stretch: cover property (enter && cause_d[2] && rst_pin_en_q ##1 drive_q);
	c_irq_raise: cover property (!irq ##1 irq);

endmodule

`default_nettype wire

/* rpms_top_bench.sv */
// Self-checking testbench of the reset pin and mode select controller.
`timescale 1ns/1ps
`default_nettype none
`include "rpms_defs.svh"

module rpms_top_bench;
	import rpms_pkg::*;
	// A short stretch keeps the run brief; every window below is derived from it.
	localparam int SB = 4;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] req = 4'h0;
	logic press = 1'b0, ms_low = 1'b0;
	logic rst_pin_i, rst_pin_o, rst_pin_oe_n, rst_pin_pullup_en, reset_pin_function, mode_select_pin_i;
	logic debug_pin_enable, background_debug_mode, sys_rst, clock_internal_sel, bus_clock, irq;
	int num_errors = 0, check_count = 0, lowc;
	logic b;

	always #20 ref_clk = ~ref_clk;

	rpms_top #(.AW(8), .STRETCH_BUS(SB)) i_dut (.ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.cop_rst_req(req[0]), .ilop_rst_req(req[1]), .ilad_rst_req(req[2]), .lvd_rst_req(req[3]), .rst_pin_i,
		.rst_pin_o, .rst_pin_oe_n, .rst_pin_pullup_en, .reset_pin_function, .mode_select_pin_i, .debug_pin_enable,
		.background_debug_mode, .sys_rst, .clock_internal_sel, .bus_clock, .irq);

	rpms_partner i_far (.ref_clk, .press, .ms_low, .rst_pin_o, .rst_pin_oe_n, .rst_pin_pullup_en, .rst_pin_i,
		.mode_select_pin_i);

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("FAIL at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Both channels are offered together; each is dropped at the edge where it is taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic got;
		got = 1'b0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 100; i++)
		begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1)
			begin
				s_axi_bready <= 1'b0;
				check(32'(s_axi_bresp), 32'(er));
				got = 1'b1;
				break;
			end
		end
		// A write that never gets its response counts as a mismatch.
		if (!got)
			check(32'h0, 32'h1);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic got;
		got = 1'b0;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 100; i++)
		begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1)
			begin
				s_axi_rready <= 1'b0;
				check(s_axi_rdata, exp);
				check(32'(s_axi_rresp), 32'(er));
				got = 1'b1;
				break;
			end
		end
		// A read that never gets its data counts as a mismatch.
		if (!got)
			check(32'h0, 32'h1);
	endtask

	// Counts the cycles the pin is driven low over one whole reset; requests drop once the reset is seen.
	task automatic run_reset(output int lc);
		logic seen;
		seen = 1'b0;
		lc = 0;
		for (int i = 0; i < 600; i++)
		begin
			@(posedge ref_clk);
			if (rst_pin_oe_n === 1'b0)
				lc++;
			if (sys_rst === 1'b1)
			begin
				seen = 1'b1;
				req <= 4'h0;
				press <= 1'b0;
			end
			if (seen && sys_rst === 1'b0)
				break;
		end
		check(32'(seen && sys_rst === 1'b0), 32'h1);
	endtask

	function automatic logic [31:0] in_window(input int lc);
		return 32'(lc >= 2 * SB - 1 && lc <= 2 * SB + 1);
	endfunction

	initial
	begin
		#(40 * 20000);
		num_errors++;
		print_verdict();
	end

	initial
	begin
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		run_reset(lowc);
		check(32'(lowc), 32'h0);
		check(32'(reset_pin_function), 32'h0);
		check(32'(rst_pin_pullup_en), 32'h0);
		check(32'({debug_pin_enable, background_debug_mode, clock_internal_sel}), 32'h5);
		rdc(`RPMS_OFS_RSS, 32'h01, `RPMS_RESP_OKAY);
		rdc(`RPMS_OFS_SOPT, 32'h02, `RPMS_RESP_OKAY);
		repeat (10) @(posedge ref_clk);
		check(32'(sys_rst), 32'h0);
		b = bus_clock;
		@(posedge ref_clk);
		check(32'(bus_clock), 32'(!b));
		rdc(8'h18, 32'h0, `RPMS_RESP_SLVERR);
		wr(8'h1C, 32'h1, `RPMS_RESP_SLVERR);
		wr(`RPMS_OFS_SOPT, 32'h1, `RPMS_RESP_OKAY);
		rdc(`RPMS_OFS_SOPT, 32'h01, `RPMS_RESP_OKAY);
		check(32'({reset_pin_function, rst_pin_pullup_en, rst_pin_oe_n, debug_pin_enable, rst_pin_o}), 32'h1C);
		wr(`RPMS_OFS_SOPT, 32'h0, `RPMS_RESP_OKAY);
		rdc(`RPMS_OFS_SOPT, 32'h01, `RPMS_RESP_OKAY);
		for (int k = 0; k < 4; k++)
		begin
			wr(`RPMS_OFS_CLK, 32'h1, `RPMS_RESP_OKAY);
			req <= 4'(1 << k);
			run_reset(lowc);
			check(in_window(lowc), 32'h1);
			check(32'({debug_pin_enable, clock_internal_sel, reset_pin_function}), 32'h7);
			rdc(`RPMS_OFS_RSS, 32'(1 << (k + 2)), `RPMS_RESP_OKAY);
			rdc(`RPMS_OFS_CLK, 32'h0, `RPMS_RESP_OKAY);
			rdc(`RPMS_OFS_IST, 32'h2, `RPMS_RESP_OKAY);
			wr(`RPMS_OFS_IST, 32'h2, `RPMS_RESP_OKAY);
		end
		wr(`RPMS_OFS_IMSK, 32'h3, `RPMS_RESP_OKAY);
		ms_low <= 1'b1;
		press <= 1'b1;
		run_reset(lowc);
		check(in_window(lowc), 32'h1);
		check(32'(background_debug_mode), 32'h0);
		rdc(`RPMS_OFS_RSS, 32'h02, `RPMS_RESP_OKAY);
		rdc(`RPMS_OFS_IST, 32'h3, `RPMS_RESP_OKAY);
		check(32'(irq), 32'h1);
		wr(`RPMS_OFS_IMSK, 32'h0, `RPMS_RESP_OKAY);
		repeat (2) @(posedge ref_clk);
		check(32'(irq), 32'h0);
		wr(`RPMS_OFS_IMSK, 32'h3, `RPMS_RESP_OKAY);
		repeat (2) @(posedge ref_clk);
		check(32'(irq), 32'h1);
		wr(`RPMS_OFS_IST, 32'h3, `RPMS_RESP_OKAY);
		repeat (2) @(posedge ref_clk);
		check(32'(irq), 32'h0);
		for (int m = 0; m < 2; m++)
		begin
			ms_low <= (m == 0);
			wr(`RPMS_OFS_FORCE, 32'h1, `RPMS_RESP_OKAY);
			run_reset(lowc);
			check(in_window(lowc), 32'h1);
			check(32'(background_debug_mode), 32'(m == 0));
			rdc(`RPMS_OFS_RSS, 32'h40, `RPMS_RESP_OKAY);
			rdc(`RPMS_OFS_CLK, 32'((m == 0) << 1), `RPMS_RESP_OKAY);
		end
		ms_low <= 1'b1;
		srst <= 1'b1;
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		run_reset(lowc);
		check(32'(lowc), 32'h0);
		check(32'({background_debug_mode, reset_pin_function, rst_pin_pullup_en}), 32'h4);
		rdc(`RPMS_OFS_RSS, 32'h01, `RPMS_RESP_OKAY);
		print_verdict();
	end
endmodule

`default_nettype wire
